// *** rtl/prd_pkg.sv ***
package prd_pkg;

  // Ternary symbol coding on the line side
  typedef logic [1:0] prd_tern_t;
  localparam prd_tern_t PRD_T_ZERO = 2'h0;
  localparam prd_tern_t PRD_T_PLUS = 2'h1;
  localparam prd_tern_t PRD_T_MINUS = 2'h3;

  typedef struct packed {
    prd_tern_t ta;
    prd_tern_t tb;
  } prd_pair_t;

  localparam prd_pair_t PRD_PAIR_ZERO = {PRD_T_ZERO, PRD_T_ZERO};
  localparam prd_pair_t PRD_PAIR_PP = {PRD_T_PLUS, PRD_T_PLUS};
  localparam prd_pair_t PRD_PAIR_MM = {PRD_T_MINUS, PRD_T_MINUS};

  // Bit packing widths and bit counts
  localparam int PRD_TRI_W = 3;
  localparam int PRD_NIB_W = 4;
  localparam int PRD_ACC_W = 6;
  localparam logic [2:0] PRD_CNT_ONE = 3'h1;
  localparam logic [2:0] PRD_CNT_TRI = 3'h3;

  // MII receive group
  typedef struct packed {
    logic dv;
    logic er;
    logic [PRD_NIB_W-1:0] rxd;
  } prd_mii_rx_t;

  localparam prd_mii_rx_t PRD_MII_IDLE = '0;

  typedef enum logic [2:0] {
    PRD_S_IDLE, PRD_S_SSD2, PRD_S_SSD3, PRD_S_DATA,
    PRD_S_ESD2, PRD_S_ESD3, PRD_S_ERR
  } prd_state_t;

  // Data pair to three bits; (0,0) carries no data
  function automatic logic [PRD_TRI_W-1:0] prd_pair_bits(input prd_pair_t p);
    logic [PRD_TRI_W-1:0] b;
    b = 3'h0;
    case ({p.ta, p.tb})
      {PRD_T_MINUS, PRD_T_MINUS}: b = 3'h0;
      {PRD_T_MINUS, PRD_T_ZERO}: b = 3'h1;
      {PRD_T_MINUS, PRD_T_PLUS}: b = 3'h2;
      {PRD_T_ZERO, PRD_T_MINUS}: b = 3'h3;
      {PRD_T_ZERO, PRD_T_PLUS}: b = 3'h4;
      {PRD_T_PLUS, PRD_T_MINUS}: b = 3'h5;
      {PRD_T_PLUS, PRD_T_ZERO}: b = 3'h6;
      {PRD_T_PLUS, PRD_T_PLUS}: b = 3'h7;
      default: b = 3'h0;
    endcase
    return b;
  endfunction

endpackage

// *** rtl/prd_pair_split.sv ***
`timescale 1ns/1ps
module prd_pair_split (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial symbols
  input wire prd_pkg::prd_tern_t sym,
  input wire logic sym_vld,
  input wire logic order_b_first,
  // Pairs
  output prd_pkg::prd_pair_t pair,
  output logic pair_vld
);
  import prd_pkg::*;

  logic phase_r;
  logic phase_nxt;
  prd_tern_t first_r;
  prd_tern_t first_nxt;
  prd_pair_t pair_r;
  prd_pair_t pair_nxt;
  logic pair_vld_r;
  logic pair_vld_nxt;

  always_comb
  begin
    phase_nxt = phase_r;
    first_nxt = first_r;
    pair_nxt = pair_r;
    pair_vld_nxt = 1'b0;
    if (sym_vld)
    begin
      phase_nxt = ~phase_r;
      if (!phase_r)
        first_nxt = sym;
      else
      begin
        pair_vld_nxt = 1'b1;
        // Either interleave order of the far end is accepted
        if (order_b_first)
          pair_nxt = '{ta: sym, tb: first_r};
        else
          pair_nxt = '{ta: first_r, tb: sym};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= 1'b0;
      first_r <= PRD_T_ZERO;
      pair_r <= PRD_PAIR_ZERO;
      pair_vld_r <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      first_r <= first_nxt;
      pair_r <= pair_nxt;
      pair_vld_r <= pair_vld_nxt;
    end
  end

  assign pair = pair_r;
  assign pair_vld = pair_vld_r;

  property p_split_order;
    @(posedge core_clk) disable iff (!rst_n)
    (sym_vld && phase_r) |=>
      pair_vld_r &&
      (pair_r == ($past(order_b_first) ?
        {$past(sym), $past(first_r)} : {$past(first_r), $past(sym)}));
  endproperty
  a_split_order: assert property (p_split_order)
    else $error("pair not formed in selected order");

endmodule // prd_pair_split

// *** rtl/prd_rx_decoder.sv ***
`timescale 1ns/1ps
module prd_rx_decoder (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Line symbols
  input wire prd_pkg::prd_tern_t rx_sym,
  input wire logic rx_sym_vld,
  input wire logic order_b_first,
  // MII receive
  output prd_pkg::prd_mii_rx_t mii_rx,
  // Status
  output logic decoder_error_flag
);
  import prd_pkg::*;

  prd_pair_t pair;
  logic pair_vld;
  prd_state_t st_r;
  prd_state_t st_nxt;
  logic [PRD_ACC_W-1:0] acc_r;
  logic [PRD_ACC_W-1:0] acc_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  prd_mii_rx_t mii_r;
  prd_mii_rx_t mii_nxt;
  logic flag_r;
  logic flag_nxt;
  logic is_zero;
  logic [PRD_ACC_W-1:0] wide;

  prd_pair_split u_split (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sym(rx_sym),
    .sym_vld(rx_sym_vld),
    .order_b_first(order_b_first),
    .pair(pair),
    .pair_vld(pair_vld)
  );

  assign is_zero = (pair == PRD_PAIR_ZERO);
  // New bits stack above the held remainder, first bit lowest
  assign wide = acc_r | (PRD_ACC_W'(prd_pair_bits(pair)) << cnt_r);

  always_comb
  begin
    st_nxt = st_r;
    acc_nxt = acc_r;
    cnt_nxt = cnt_r;
    mii_nxt = PRD_MII_IDLE;
    unique case (st_r)
      PRD_S_IDLE:
        if (pair_vld && is_zero)
          st_nxt = PRD_S_SSD2;
      PRD_S_SSD2:
        if (pair_vld)
          st_nxt = is_zero ? PRD_S_SSD3 : PRD_S_ERR;
      PRD_S_SSD3:
        if (pair_vld)
        begin
          st_nxt = is_zero ? PRD_S_DATA : PRD_S_ERR;
          acc_nxt = '0;
          cnt_nxt = '0;
        end
      PRD_S_DATA:
        if (pair_vld)
        begin
          if (is_zero)
          begin
            // Remainder below a nibble is padding, never data
            st_nxt = PRD_S_ESD2;
            acc_nxt = '0;
            cnt_nxt = '0;
          end
          else if (cnt_r >= PRD_CNT_ONE)
          begin
            mii_nxt.dv = 1'b1;
            mii_nxt.rxd = wide[PRD_NIB_W-1:0];
            acc_nxt = wide >> PRD_NIB_W;
            cnt_nxt = cnt_r - PRD_CNT_ONE;
          end
          else
          begin
            acc_nxt = wide;
            cnt_nxt = PRD_CNT_TRI;
          end
        end
      PRD_S_ESD2:
        if (pair_vld)
          st_nxt = is_zero ? PRD_S_ESD3 : PRD_S_ERR;
      PRD_S_ESD3:
        if (pair_vld)
          st_nxt = (pair == PRD_PAIR_PP) ? PRD_S_IDLE : PRD_S_ERR;
      PRD_S_ERR:
        st_nxt = PRD_S_IDLE;
    endcase
    // Error shown together with data-valid so the MAC drops the frame
    if (st_nxt == PRD_S_ERR)
    begin
      mii_nxt.dv = 1'b1;
      mii_nxt.er = 1'b1;
    end
  end

  assign flag_nxt = (st_nxt == PRD_S_ERR);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= PRD_S_IDLE;
      acc_r <= '0;
      cnt_r <= '0;
      mii_r <= PRD_MII_IDLE;
      flag_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      mii_r <= mii_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign mii_rx = mii_r;
  assign decoder_error_flag = flag_r;

  property p_err_esd3;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_ESD3 && pair_vld && pair != PRD_PAIR_PP) |=>
      (st_r == PRD_S_ERR) && flag_r ##1 (st_r == PRD_S_IDLE) && !flag_r;
  endproperty
  a_err_esd3: assert property (p_err_esd3)
    else $error("bad end delimiter did not enter error state");

  property p_rx_er;
    @(posedge core_clk) disable iff (!rst_n)
    (mii_r.er == flag_r) && (!mii_r.er || mii_r.dv);
  endproperty
  a_rx_er: assert property (p_rx_er)
    else $error("receive error not tied to decoder error");

  property p_stuff_drop;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_DATA && pair_vld && is_zero) |=>
      !mii_r.dv && cnt_r == 3'h0 && acc_r == '0;
  endproperty
  a_stuff_drop: assert property (p_stuff_drop)
    else $error("stuff bits reached the nibble path");

  property p_nibble_rate;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_DATA && pair_vld && !is_zero) |=>
      (mii_r.dv == ($past(cnt_r) != 3'h0)) &&
      (cnt_r == (($past(cnt_r) == 3'h0) ? 3'h3 : $past(cnt_r) - 3'h1));
  endproperty
  a_nibble_rate: assert property (p_nibble_rate)
    else $error("nibble count does not follow bit count");

  property p_ssd;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_SSD3 && pair_vld && is_zero) |=>
      st_r == PRD_S_DATA && cnt_r == 3'h0;
  endproperty
  a_ssd: assert property (p_ssd)
    else $error("start delimiter not accepted");

  property p_esd_ok;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_ESD3 && pair_vld && pair == PRD_PAIR_PP) |=>
      st_r == PRD_S_IDLE && !mii_r.er && !flag_r;
  endproperty
  a_esd_ok: assert property (p_esd_ok)
    else $error("valid end delimiter not closed cleanly");

  property p_dv_source;
    @(posedge core_clk) disable iff (!rst_n)
    (mii_r.dv && !mii_r.er) |->
      $past(st_r) == PRD_S_DATA && $past(pair_vld) && !$past(is_zero);
  endproperty
  a_dv_source: assert property (p_dv_source)
    else $error("data-valid without a data pair");

  property p_err_other;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_SSD2 && pair_vld && !is_zero) |=>
      mii_r.er ##1 !mii_r.er;
  endproperty
  a_err_other: assert property (p_err_other)
    else $error("bad start delimiter not flagged for one cycle");

  property p_ssd_bad;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_SSD3 && pair_vld && !is_zero) |=>
      st_r == PRD_S_ERR && mii_r.er && flag_r;
  endproperty
  a_ssd_bad: assert property (p_ssd_bad)
    else $error("bad third start pair not refused");

  property p_esd2_bad;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_ESD2 && pair_vld && !is_zero) |=>
      mii_r.er && mii_r.dv && flag_r;
  endproperty
  a_esd2_bad: assert property (p_esd2_bad)
    else $error("bad second end pair not flagged");

  property p_idle_quiet;
    @(posedge core_clk) disable iff (!rst_n)
    (st_r == PRD_S_IDLE) |=> !mii_r.dv;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("data-valid outside a frame");

endmodule // prd_rx_decoder

// *** verif/prd_link_tx.sv ***
`timescale 1ns/1ps
module prd_link_tx (
  // Clock
  input wire logic core_clk,
  // Line symbols
  output prd_pkg::prd_tern_t sym,
  output logic sym_vld,
  output logic order_b_first
);
  import prd_pkg::*;

  initial
  begin
    sym = PRD_T_ZERO;
    sym_vld = 1'b0;
    order_b_first = 1'b0;
  end

  function automatic prd_tern_t tern(input int d);
    return (d == 0) ? PRD_T_MINUS : (d == 1) ? PRD_T_ZERO : PRD_T_PLUS;
  endfunction

  // Skips the (0,0) code point, kept for delimiters
  function automatic prd_pair_t enc(input logic [2:0] v);
    int k;
    k = (v < 3'h4) ? int'(v) : int'(v) + 1;
    return {tern(k / 3), tern(k % 3)};
  endfunction

  // Random stalls; a stalled line shows noise, not the last symbol
  task automatic put(input prd_tern_t s);
    while ($urandom % 4 == 0)
    begin
      sym <= 2'($urandom);
      sym_vld <= 1'b0;
      @(posedge core_clk);
    end
    sym <= s;
    sym_vld <= 1'b1;
    @(posedge core_clk);
  endtask

  task automatic pair(input prd_pair_t p);
    put(order_b_first ? p.tb : p.ta);
    put(order_b_first ? p.ta : p.tb);
  endtask

  // Kind 0 good, 1 bad third end pair, 2 bad second start pair,
  // 3 bad third start pair, 4 bad second end pair
  task automatic send_frame(input bit ob, input int kind,
                            input logic [3:0] nib[$]);
    logic bits[$];
    logic [2:0] v;
    order_b_first <= ob;
    pair({PRD_T_PLUS, PRD_T_MINUS});
    pair(PRD_PAIR_ZERO);
    pair(kind == 2 ? PRD_PAIR_PP : PRD_PAIR_ZERO);
    if (kind != 2)
      pair(kind == 3 ? PRD_PAIR_MM : PRD_PAIR_ZERO);
    if (kind != 2 && kind != 3)
    begin
      foreach (nib[i])
        for (int j = 0; j < 4; j++)
          bits.push_back(nib[i][j]);
      while (bits.size() % 3 != 0)
        bits.push_back(1'($urandom));
      while (bits.size() > 0)
      begin
        for (int j = 0; j < 3; j++)
          v[j] = bits.pop_front();
        pair(enc(v));
      end
      pair(PRD_PAIR_ZERO);
      pair(kind == 4 ? PRD_PAIR_PP : PRD_PAIR_ZERO);
      pair(kind == 1 ? enc(3'($urandom % 7)) : PRD_PAIR_PP);
    end
    pair({PRD_T_PLUS, PRD_T_MINUS});
    sym <= 2'($urandom);
    sym_vld <= 1'b0;
  endtask
endmodule // prd_link_tx

// *** verif/pcs_receive_decode_checks_bench.sv ***
`timescale 1ns/1ps
module pcs_receive_decode_checks_bench;
  import prd_pkg::*;
  logic core_clk;
  logic rst_n;
  prd_tern_t rx_sym;
  logic rx_sym_vld;
  logic order_b_first;
  prd_mii_rx_t mii_rx;
  logic decoder_error_flag;
  int failures;
  int checks_done;
  int n_err;
  logic [3:0] sent[$];
  logic [3:0] got[$];

  prd_rx_decoder i_prd_rx_decoder (
    .core_clk(core_clk), .rst_n(rst_n),
    .rx_sym(rx_sym), .rx_sym_vld(rx_sym_vld),
    .order_b_first(order_b_first),
    .mii_rx(mii_rx), .decoder_error_flag(decoder_error_flag)
  );

  prd_link_tx i_prd_link_tx (
    .core_clk(core_clk), .sym(rx_sym), .sym_vld(rx_sym_vld),
    .order_b_first(order_b_first)
  );

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    checks_done++;
    if (exp !== seen)
    begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Sampled mid-cycle, where the registered outputs have settled
  always @(negedge core_clk)
  begin
    if (mii_rx.dv === 1'b1 && mii_rx.er === 1'b0)
      got.push_back(mii_rx.rxd);
    if (mii_rx.er !== 1'b0 || decoder_error_flag !== 1'b0)
    begin
      n_err++;
      chk("err_flag", 8'h03, {6'h0, mii_rx.er, decoder_error_flag});
      chk("err_dv_rxd", 8'h10, {3'h0, mii_rx.dv, mii_rx.rxd});
    end
  end

  task automatic frame(input bit ob, input int kind, input int nbytes);
    int exp_n;
    sent.delete();
    got.delete();
    n_err = 0;
    repeat (2 * nbytes) sent.push_back(4'($urandom));
    i_prd_link_tx.send_frame(ob, kind, sent);
    repeat (4) @(posedge core_clk);
    exp_n = (kind == 2 || kind == 3) ? 0 : sent.size();
    chk("nib_count", 8'(exp_n), 8'(got.size()));
    for (int i = 0; i < exp_n && i < got.size(); i++)
      chk("nibble", {4'h0, sent[i]}, {4'h0, got[i]});
    chk("errors", 8'(kind != 0), 8'(n_err));
    $display("frame order %0d kind %0d bytes %0d done", ob, kind, nbytes);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Longest run is about 6200 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    void'($urandom(66442));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    frame(1'b1, 1, 1);
    frame(1'b0, 0, 1);
    frame(1'b1, 2, 1);
    frame(1'b0, 3, 2);
    frame(1'b1, 4, 2);
    for (int i = 0; i < 18; i++)
      frame(i % 2, i / 6, 64 + (i % 6));
    report_and_stop();
  end
endmodule // pcs_receive_decode_checks_bench
